// file: rtl/itgc_defines.svh
// Purpose: Constants of the I2C target with general call handling.
// Assumes: Included by the target module and the bench.
`ifndef ITGC_DEFINES_SVH
`define ITGC_DEFINES_SVH
`define ITGC_ADDR_PREFIX  4'h9
`define ITGC_GC_ADDR      8'h00
`define ITGC_GC_RESET     8'h06
`define ITGC_GC_ALT       8'h04
`define ITGC_HS_CODE      5'h01
`define ITGC_CFG_DEFAULT  8'h8C
`define ITGC_FILL_BYTE    8'hFF
`define ITGC_OUT_RESET    16'h0000
`define ITGC_BITS_BYTE    4'h8
`define ITGC_IDX_CFG      2'h2
`define ITGC_IDX_LAST     2'h3
`define ITGC_FILT_FS      3'h2
`define ITGC_FILT_HS      3'h0
`define ITGC_CFG_DRDY     7
`define ITGC_CFG_SC       4
`define ITGC_CFG_DR_HI    3
`define ITGC_CFG_DR_LO    2
`define ITGC_CFG_PGA_HI   1
`define ITGC_CFG_PGA_LO   0
`define ITGC_CFG_WR_HI    4
`endif

// file: rtl/itgc_pkg.sv
// Purpose: Types of the I2C target with general call handling.
// Assumes: Constants come from itgc_defines.svh.
// Notes: Line index 0 is SCL and index 1 is SDA in all pin vectors.
package itgc_pkg;
  typedef enum logic [7:0] {
    L_IDLE = 8'h01,
    L_ADDR = 8'h02,
    L_ACK  = 8'h04,
    L_WR   = 8'h08,
    L_GC   = 8'h10,
    L_RD   = 8'h20,
    L_RACK = 8'h40,
    L_IGN  = 8'h80
  } itgc_lst_e;

  typedef struct packed {
    logic [1:0]      pin_s1;
    logic [1:0]      pin_s2;
    logic [1:0]      filt;
    logic [1:0]      fprev;
    logic [1:0][2:0] fcnt;
    itgc_lst_e       st;
    itgc_lst_e       after;
    logic [3:0]      cnt;
    logic [7:0]      sh;
    logic [7:0]      tx;
    logic [1:0]      idx;
    logic            wr_done;
    logic            nack;
    logic            oe_n;
    logic            hs;
    logic            hold;
    logic [2:0]      ack_s;
    logic [23:0]     snap;
    logic [7:0]      wr_byte;
    logic            wr_tgl;
    logic            gc_tgl;
    logic            rd_tgl;
  } itgc_link_s;

  typedef struct packed {
    logic [2:0]  wr_s;
    logic [2:0]  gc_s;
    logic [2:0]  rd_s;
    logic [1:0]  hold_s;
    logic [1:0]  hs_s;
    logic [7:0]  cfg;
    logic [15:0] outr;
    logic [23:0] mirror;
    logic        hold_ack;
    logic        start;
    logic        abort;
  } itgc_core_s;
endpackage : itgc_pkg

// file: rtl/itgc_target.sv
// Purpose: I2C target with address match, general call reset and high-speed entry.
// Assumes: BUS_CLK is a free-running sampling oscillator far faster than SCL.
// Notes: Register contents cross by toggles and a hold handshake; bus logic never stalls SCL.
`timescale 1ns/1ps
`include "itgc_defines.svh"
module itgc_target
  import itgc_pkg::*;
#(
  parameter logic [2:0] ADDR_VAR = 3'h0
)
(
  // Clocks and reset
  input  wire logic        REF_CLK,
  input  wire logic        BUS_CLK,
  input  wire logic        RESET_N,
  // Bus pins
  input  wire logic        SCL_IN,
  input  wire logic        SDA_IN,
  output logic             SDA_OUT,
  output logic             SDA_OE_N,
  // Converter side
  input  wire logic        CONV_VALID,
  input  wire logic [15:0] CONV_DATA,
  input  wire logic        CONV_BUSY,
  output logic             CONV_START,
  output logic             CONV_ABORT,
  output logic             CFG_SC,
  output logic [1:0]       CFG_DR,
  output logic [1:0]       CFG_PGA,
  output logic             HS_MODE
);
  itgc_link_s lr;
  itgc_link_s ln;
  itgc_core_s cr;
  itgc_core_s cn;
  logic [1:0] lrst_ff;
  logic       link_rst_n;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_c;
  logic       stop_c;
  logic       byte_end;
  logic       wr_ev;
  logic       gc_ev;
  logic       rd_ev;
  logic [2:0] thr;

  // Reset release is synchronised to the bus clock; assertion stays asynchronous.
  always_ff @(posedge BUS_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      lrst_ff <= 2'h0;
    end
    else
    begin
      lrst_ff <= {lrst_ff[0], 1'b1};
    end
  end
  assign link_rst_n = lrst_ff[1];

  // Events come from the filtered lines only, one cycle after they settle.
  assign scl_rise = lr.filt[0] & ~lr.fprev[0];
  assign scl_fall = ~lr.filt[0] & lr.fprev[0];
  assign start_c  = lr.fprev[1] & ~lr.filt[1] & lr.filt[0] & lr.fprev[0];
  assign stop_c   = ~lr.fprev[1] & lr.filt[1] & lr.filt[0] & lr.fprev[0];
  assign byte_end = scl_fall && (lr.cnt == `ITGC_BITS_BYTE);
  assign thr      = lr.hs ? `ITGC_FILT_HS : `ITGC_FILT_FS;

  // Open drain: the data is always low and only the enable moves; SCL has no driver.
  assign SDA_OUT  = 1'b0;
  assign SDA_OE_N = lr.oe_n;

  always_comb
  begin
    logic [7:0] nb;
    nb = `ITGC_FILL_BYTE;
    unique case (lr.idx)
      2'h0: nb = lr.snap[23:16];
      2'h1: nb = lr.snap[15:8];
      2'h2: nb = lr.snap[7:0];
      default: nb = `ITGC_FILL_BYTE;
    endcase
    ln = lr;
    ln.pin_s1 = {SDA_IN, SCL_IN};
    ln.pin_s2 = lr.pin_s1;
    ln.fprev  = lr.filt;
    for (int i = 0; i < 2; i++)
    begin
      if (lr.pin_s2[i] == lr.filt[i])
      begin
        ln.fcnt[i] = 3'h0;
      end
      else if (lr.fcnt[i] >= thr)
      begin
        ln.filt[i] = lr.pin_s2[i];
        ln.fcnt[i] = 3'h0;
      end
      else
      begin
        ln.fcnt[i] = lr.fcnt[i] + 3'h1;
      end
    end
    ln.ack_s = {lr.ack_s[1:0], cr.hold_ack};
    if (lr.ack_s[1] && !lr.ack_s[2])
    begin
      ln.snap = cr.mirror;
    end
    if (stop_c)
    begin
      ln.st   = L_IDLE;
      ln.oe_n = 1'b1;
      ln.hs   = 1'b0;
      ln.hold = 1'b0;
    end
    else if (start_c)
    begin
      ln.st      = L_ADDR;
      ln.cnt     = 4'h0;
      ln.oe_n    = 1'b1;
      ln.hold    = 1'b1;
      ln.idx     = 2'h0;
      ln.wr_done = 1'b0;
    end
    else
    begin
      unique case (lr.st)
        L_IDLE, L_IGN:
        begin
          ln.oe_n = 1'b1;
        end
        L_ADDR, L_WR, L_GC:
        begin
          if (scl_rise && lr.cnt != `ITGC_BITS_BYTE)
          begin
            ln.sh  = {lr.sh[6:0], lr.filt[1]};
            ln.cnt = lr.cnt + 4'h1;
          end
          else if (byte_end)
          begin
            ln.cnt = 4'h0;
            if (lr.st == L_ADDR)
            begin
              if (lr.sh[7:1] == {`ITGC_ADDR_PREFIX, ADDR_VAR})
              begin
                ln.oe_n  = 1'b0;
                ln.st    = L_ACK;
                ln.after = lr.sh[0] ? L_RD : L_WR;
              end
              else if (lr.sh == `ITGC_GC_ADDR)
              begin
                ln.oe_n  = 1'b0;
                ln.st    = L_ACK;
                ln.after = L_GC;
              end
              else
              begin
                ln.st = L_IGN;
                if (lr.sh[7:3] == `ITGC_HS_CODE)
                begin
                  ln.hs = 1'b1;
                end
              end
            end
            else if (lr.st == L_WR)
            begin
              if (!lr.wr_done)
              begin
                ln.oe_n    = 1'b0;
                ln.st      = L_ACK;
                ln.after   = L_WR;
                ln.wr_done = 1'b1;
                ln.wr_byte = lr.sh;
                ln.wr_tgl  = ~lr.wr_tgl;
              end
              else
              begin
                // Later bytes are ignored whole, so their acknowledge clock is never shifted in as data.
                ln.st = L_IGN;
              end
            end
            else if (lr.sh == `ITGC_GC_RESET || lr.sh == `ITGC_GC_ALT)
            begin
              ln.oe_n  = 1'b0;
              ln.st    = L_ACK;
              ln.after = L_GC;
              if (lr.sh == `ITGC_GC_RESET)
              begin
                ln.gc_tgl = ~lr.gc_tgl;
              end
            end
            else
            begin
              ln.st = L_IGN;
            end
          end
        end
        L_ACK:
        begin
          if (scl_fall)
          begin
            ln.oe_n = 1'b1;
            ln.st   = lr.after;
            if (lr.after == L_RD)
            begin
              ln.tx   = nb;
              ln.oe_n = nb[7];
              ln.idx  = (lr.idx == `ITGC_IDX_LAST) ? lr.idx : lr.idx + 2'h1;
              if (lr.idx == `ITGC_IDX_CFG)
              begin
                ln.rd_tgl = ~lr.rd_tgl;
              end
            end
          end
        end
        L_RD:
        begin
          if (scl_rise && lr.cnt != `ITGC_BITS_BYTE)
          begin
            ln.cnt = lr.cnt + 4'h1;
          end
          else if (byte_end)
          begin
            ln.oe_n = 1'b1;
            ln.st   = L_RACK;
            ln.cnt  = 4'h0;
          end
          else if (scl_fall)
          begin
            ln.tx   = {lr.tx[6:0], 1'b1};
            ln.oe_n = lr.tx[6];
          end
        end
        L_RACK:
        begin
          if (scl_rise)
          begin
            ln.nack = lr.filt[1];
          end
          else if (scl_fall)
          begin
            if (lr.nack)
            begin
              ln.st = L_IGN;
            end
            else
            begin
              ln.st   = L_RD;
              ln.tx   = nb;
              ln.oe_n = nb[7];
              ln.idx  = (lr.idx == `ITGC_IDX_LAST) ? lr.idx : lr.idx + 2'h1;
              if (lr.idx == `ITGC_IDX_CFG)
              begin
                ln.rd_tgl = ~lr.rd_tgl;
              end
            end
          end
        end
        default:
        begin
          ln.st = L_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge BUS_CLK or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      lr       <= '0;
      lr.st    <= L_IDLE;
      lr.after <= L_IDLE;
      lr.pin_s1 <= 2'h3;
      lr.pin_s2 <= 2'h3;
      lr.filt  <= 2'h3;
      lr.fprev <= 2'h3;
      lr.oe_n  <= 1'b1;
    end
    else
    begin
      lr <= ln;
    end
  end

  // Core side: toggles arrive through three flops, the edge is taken between the last two.
  assign wr_ev = cr.wr_s[1] ^ cr.wr_s[2];
  assign gc_ev = cr.gc_s[1] ^ cr.gc_s[2];
  assign rd_ev = cr.rd_s[1] ^ cr.rd_s[2];

  always_comb
  begin
    cn = cr;
    cn.wr_s     = {cr.wr_s[1:0], lr.wr_tgl};
    cn.gc_s     = {cr.gc_s[1:0], lr.gc_tgl};
    cn.rd_s     = {cr.rd_s[1:0], lr.rd_tgl};
    cn.hold_s   = {cr.hold_s[0], lr.hold};
    cn.hs_s     = {cr.hs_s[0], lr.hs};
    cn.hold_ack = cr.hold_s[1];
    cn.start    = 1'b0;
    cn.abort    = 1'b0;
    // The mirror freezes for the whole transaction so the bytes read belong together.
    if (!cr.hold_s[1])
    begin
      cn.mirror = {cr.outr, cr.cfg};
    end
    if (rd_ev)
    begin
      cn.cfg[`ITGC_CFG_DRDY] = 1'b1;
    end
    if (CONV_VALID)
    begin
      cn.outr                = CONV_DATA;
      cn.cfg[`ITGC_CFG_DRDY] = 1'b0;
    end
    if (wr_ev)
    begin
      cn.cfg[`ITGC_CFG_WR_HI:0] = lr.wr_byte[`ITGC_CFG_WR_HI:0];
      cn.start = lr.wr_byte[`ITGC_CFG_DRDY] & lr.wr_byte[`ITGC_CFG_SC] & ~CONV_BUSY;
    end
    if (gc_ev)
    begin
      cn.cfg   = `ITGC_CFG_DEFAULT;
      cn.outr  = `ITGC_OUT_RESET;
      cn.abort = 1'b1;
      cn.start = 1'b0;
    end
  end

  always_ff @(posedge REF_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      cr      <= '0;
      cr.cfg  <= `ITGC_CFG_DEFAULT;
      cr.outr <= `ITGC_OUT_RESET;
    end
    else
    begin
      cr <= cn;
    end
  end

  assign CONV_START = cr.start;
  assign CONV_ABORT = cr.abort;
  assign CFG_SC     = cr.cfg[`ITGC_CFG_SC];
  assign CFG_DR     = cr.cfg[`ITGC_CFG_DR_HI:`ITGC_CFG_DR_LO];
  assign CFG_PGA    = cr.cfg[`ITGC_CFG_PGA_HI:`ITGC_CFG_PGA_LO];
  assign HS_MODE    = cr.hs_s[1];

  a_addr_match_ack: assert property (@(posedge BUS_CLK) disable iff (!link_rst_n)
    (lr.st == L_ADDR && byte_end && !start_c && !stop_c && lr.sh[7:1] == {`ITGC_ADDR_PREFIX, ADDR_VAR})
    |=> (lr.st == L_ACK && !SDA_OE_N))
    else $error("Matching address not acknowledged.");
  a_hs_code_nack: assert property (@(posedge BUS_CLK) disable iff (!link_rst_n)
    (lr.st == L_ADDR && byte_end && !start_c && !stop_c && lr.sh[7:3] == `ITGC_HS_CODE)
    |=> (lr.st == L_IGN && lr.hs && SDA_OE_N))
    else $error("High-speed code acknowledged or mode not entered.");
  a_hs_stop_exit: assert property (@(posedge BUS_CLK) disable iff (!link_rst_n)
    stop_c |=> !lr.hs ##4 !HS_MODE)
    else $error("High-speed mode not left at STOP.");
  a_gc_data_nack: assert property (@(posedge BUS_CLK) disable iff (!link_rst_n)
    (lr.st == L_GC && byte_end && !start_c && !stop_c && lr.sh != `ITGC_GC_RESET && lr.sh != `ITGC_GC_ALT)
    |=> (lr.st == L_IGN && SDA_OE_N))
    else $error("Unexpected general call data acknowledged.");
  a_wr_extra_nack: assert property (@(posedge BUS_CLK) disable iff (!link_rst_n)
    (lr.st == L_WR && lr.wr_done && byte_end && !start_c && !stop_c) |=> (SDA_OE_N && $stable(lr.wr_tgl)))
    else $error("Second write byte acknowledged.");
  a_restart_addr: assert property (@(posedge BUS_CLK) disable iff (!link_rst_n)
    (start_c && !stop_c) |=> (lr.st == L_ADDR && lr.cnt == 4'h0 && SDA_OE_N))
    else $error("START did not begin an address phase.");
  a_fill_bytes: assert property (@(posedge BUS_CLK) disable iff (!link_rst_n)
    (lr.st == L_RACK && scl_fall && !lr.nack && lr.idx == `ITGC_IDX_LAST && !start_c && !stop_c)
    |=> lr.tx == `ITGC_FILL_BYTE)
    else $error("Byte after configuration not all ones.");
  a_drive_only_read: assert property (@(posedge BUS_CLK) disable iff (!link_rst_n)
    !SDA_OE_N |-> (lr.st == L_ACK || lr.st == L_RD))
    else $error("SDA pulled low outside acknowledge or read.");
  a_gc_full_reset: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    gc_ev |=> (cr.cfg == `ITGC_CFG_DEFAULT && cr.outr == `ITGC_OUT_RESET && CONV_ABORT && !CONV_START))
    else $error("General call reset incomplete.");
  a_cfg_write_load: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    (wr_ev && !gc_ev) |=> CFG_SC == $past(lr.wr_byte[`ITGC_CFG_SC]) && CFG_PGA == $past(lr.wr_byte[1:0]))
    else $error("Configuration write not loaded.");
  a_new_data_flag: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    (CONV_VALID && !gc_ev) |=> (!cr.cfg[`ITGC_CFG_DRDY] && cr.outr == $past(CONV_DATA)))
    else $error("New conversion not flagged.");

  c_gc_reset: cover property (@(posedge REF_CLK) disable iff (!RESET_N) gc_ev);
  c_cfg_read: cover property (@(posedge BUS_CLK) disable iff (!link_rst_n)
    (lr.st == L_RD && lr.idx == `ITGC_IDX_LAST));
  c_hs_entry: cover property (@(posedge BUS_CLK) disable iff (!link_rst_n) lr.hs);
  c_cfg_write: cover property (@(posedge REF_CLK) disable iff (!RESET_N) wr_ev);
endmodule : itgc_target

// file: bench/itgc_ctl_model.sv
// Purpose: Behavioural bus controller that drives SCL and pulls SDA for the target bench.
// Assumes: Called from the bench right after a rising edge of ref_clk.
// Notes: Each bit spends one quarter with SCL low, two quarters high, one quarter low again.
`timescale 1ns/1ps
module itgc_ctl_model
#(
  parameter int Q = 64
)
(
  // Clock
  input  wire logic ref_clk,
  // Bus lines
  input  wire logic sda,
  output logic      scl,
  output logic      sda_pull
);
  initial
  begin
    scl      = 1'b1;
    sda_pull = 1'b0;
  end

  task automatic quarter();
    repeat (Q) @(posedge ref_clk);
  endtask : quarter

  // Data is only pulled low or released, and only changes while SCL is low.
  task automatic one_bit(input logic b, output logic got);
    sda_pull <= ~b;
    quarter();
    scl <= 1'b1;
    quarter();
    got = sda;
    quarter();
    scl <= 1'b0;
    quarter();
  endtask : one_bit

  // Also serves as a repeated START when the bus is still active.
  task automatic start_cond();
    sda_pull <= 1'b0;
    quarter();
    scl <= 1'b1;
    quarter();
    sda_pull <= 1'b1;
    quarter();
    scl <= 1'b0;
    quarter();
  endtask : start_cond

  task automatic stop_cond();
    sda_pull <= 1'b1;
    quarter();
    scl <= 1'b1;
    quarter();
    sda_pull <= 1'b0;
    quarter();
    quarter();
  endtask : stop_cond

  // Sending all ones releases SDA so the target can drive it on a read.
  task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--)
      one_bit(tx[i], rx[i]);
    one_bit(ack_in, ack);
  endtask : xfer
endmodule : itgc_ctl_model

// file: bench/tb.sv
// Purpose: Self-checking bench of the bus target with general call handling.
// Assumes: SCL quarter of 64 core cycles keeps every phase well above the filter delay.
// Notes: Converter busy is tied low; the converter is mimicked by one result pulse.
`timescale 1ns/1ps
`include "itgc_defines.svh"
module tb;
  import itgc_pkg::*;
  localparam logic [2:0] VAR   = 3'h5;
  localparam logic [6:0] DEV   = {4'h9, VAR};
  localparam int         LIMIT = 95000;
  logic        ref_clk;
  logic        bus_clk;
  logic        reset_n;
  logic        conv_valid;
  logic [15:0] conv_data;
  logic        conv_busy;
  logic        scl;
  logic        pull;
  logic        sda_out;
  logic        sda_oe_n;
  logic        conv_start;
  logic        conv_abort;
  logic        cfg_sc;
  logic [1:0]  cfg_dr;
  logic [1:0]  cfg_pga;
  logic        hs_mode;
  wire         sda = ~pull & (sda_oe_n | sda_out);
  int          err_total = 0;
  int          n_compared = 0;
  int          n_start = 0;
  int          n_abort = 0;
  int          cycles = 0;

  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  initial
  begin
    bus_clk = 1'b0;
    #3;
    forever #32 bus_clk = ~bus_clk;
  end

  itgc_target #(.ADDR_VAR(VAR)) i_dut (
    .REF_CLK(ref_clk), .BUS_CLK(bus_clk), .RESET_N(reset_n), .SCL_IN(scl), .SDA_IN(sda),
    .SDA_OUT(sda_out), .SDA_OE_N(sda_oe_n), .CONV_VALID(conv_valid), .CONV_DATA(conv_data),
    .CONV_BUSY(conv_busy), .CONV_START(conv_start), .CONV_ABORT(conv_abort), .CFG_SC(cfg_sc),
    .CFG_DR(cfg_dr), .CFG_PGA(cfg_pga), .HS_MODE(hs_mode)
  );

  itgc_ctl_model #(.Q(64)) i_ctl (.ref_clk(ref_clk), .sda(sda), .scl(scl), .sda_pull(pull));

  always @(posedge ref_clk)
  begin
    cycles++;
    if (conv_start === 1'b1)
      n_start++;
    if (conv_abort === 1'b1)
      n_abort++;
    if (cycles == LIMIT)
    begin
      err_total++;
      results();
    end
  end

  task automatic results();
    if (err_total == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : results

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : idle

  function automatic logic [15:0] cfg_pins();
    return 16'({cfg_sc, cfg_dr, cfg_pga});
  endfunction : cfg_pins

  // One address byte and one data byte, returning both acknowledge bits.
  task automatic wr2(input logic [7:0] a8, input logic [7:0] d, output logic [1:0] acks);
    logic [7:0] rx;
    i_ctl.start_cond();
    i_ctl.xfer(a8, 1'b1, rx, acks[1]);
    i_ctl.xfer(d, 1'b1, rx, acks[0]);
  endtask : wr2

  task automatic t_reset();
    chk("cfg pins", cfg_pins(), 16'(`ITGC_CFG_DEFAULT & 8'h1F));
    chk("hs mode", 16'(hs_mode), 16'h0000);
    chk("sda idle", 16'({sda_out, sda_oe_n}), 16'h0001);
  endtask : t_reset

  task automatic t_write();
    logic [7:0] rx;
    logic [1:0] acks;
    logic       a;
    wr2({DEV, 1'b0}, 8'h13, acks);
    chk("write acks", 16'(acks), 16'h0000);
    i_ctl.xfer(8'hAA, 1'b1, rx, a);
    chk("extra byte", 16'(a), 16'h0001);
    i_ctl.stop_cond();
    idle(40);
    chk("cfg pins", cfg_pins(), 16'h0013);
    chk("no start", 16'(n_start), 16'h0000);
    wr2({DEV, 1'b0}, 8'h9E, acks);
    i_ctl.stop_cond();
    idle(40);
    chk("cfg pins", cfg_pins(), 16'h001E);
    chk("start", 16'(n_start), 16'h0001);
  endtask : t_write

  task automatic t_read(input logic [31:0] exp, input string what);
    logic [7:0] rx;
    logic       a;
    i_ctl.start_cond();
    i_ctl.xfer({DEV, 1'b1}, 1'b1, rx, a);
    chk("read addr", 16'(a), 16'h0000);
    for (int i = 0; i < 4; i++)
    begin
      i_ctl.xfer(8'hFF, (i == 3), rx, a);
      chk(what, 16'(rx), 16'(exp[31 - 8 * i -: 8]));
    end
    i_ctl.stop_cond();
    idle(40);
  endtask : t_read

  // A refused address, then a repeated START that reads the result.
  task automatic t_restart();
    logic [7:0] rx;
    logic       a;
    conv_data  <= 16'hA5C3;
    conv_valid <= 1'b1;
    idle(1);
    conv_valid <= 1'b0;
    idle(10);
    i_ctl.start_cond();
    i_ctl.xfer({4'h9, VAR ^ 3'h1, 1'b1}, 1'b1, rx, a);
    chk("other addr", 16'(a), 16'h0001);
    t_read({16'hA5C3, 8'h1E, `ITGC_FILL_BYTE}, "read byte");
  endtask : t_restart

  task automatic t_gc();
    logic [7:0] codes [3] = '{8'h05, 8'h04, 8'h06};
    logic [1:0] acks;
    foreach (codes[i])
    begin
      wr2(`ITGC_GC_ADDR, codes[i], acks);
      chk("gc acks", 16'(acks), 16'(codes[i] == 8'h05));
      i_ctl.stop_cond();
      idle(40);
      chk("abort", 16'(n_abort), 16'(i == 2));
    end
    chk("cfg pins", cfg_pins(), 16'(`ITGC_CFG_DEFAULT & 8'h1F));
    t_read({`ITGC_OUT_RESET, `ITGC_CFG_DEFAULT, `ITGC_FILL_BYTE}, "gc read");
  endtask : t_gc

  task automatic t_hs();
    logic [7:0] rx;
    logic       a;
    i_ctl.start_cond();
    i_ctl.xfer(8'h0B, 1'b1, rx, a);
    chk("hs code", 16'(a), 16'h0001);
    idle(10);
    chk("hs on", 16'(hs_mode), 16'h0001);
    i_ctl.start_cond();
    i_ctl.xfer({DEV, 1'b0}, 1'b1, rx, a);
    chk("hs addr", 16'(a), 16'h0000);
    i_ctl.stop_cond();
    idle(40);
    chk("hs off", 16'(hs_mode), 16'h0000);
  endtask : t_hs

  // Reset is held for eight cycles of the slower bus clock, as the link needs two at least.
  initial
  begin
    reset_n    = 1'b0;
    conv_valid = 1'b0;
    conv_data  = 16'h0000;
    conv_busy  = 1'b0;
    repeat (8) @(posedge bus_clk);
    @(posedge ref_clk);
    reset_n <= 1'b1;
    idle(80);
    t_reset();
    t_write();
    t_restart();
    t_gc();
    t_hs();
    results();
  end
endmodule : tb
